// *** shared/irq_enable_consts.vh ***
// Constants of the interrupt enable bank: register offsets, masks of the
// implemented enable bits, reset values and bus answer codes.
// Assumes an 8-bit byte address on the register bus and 32-bit data.
`ifndef IRQ_ENABLE_CONSTS_VH
`define IRQ_ENABLE_CONSTS_VH

// Width of the register bus byte address.
`define REG_ADDR_W      8

// Byte offsets of the five enable words.
`define OFS_ENABLE0     8'h00
`define OFS_ENABLE1     8'h04
`define OFS_ENABLE2     8'h08
`define OFS_ENABLE3     8'h0c
`define OFS_ENABLE4     8'h10

// Byte offsets of the five read-only gated request words.
`define OFS_REQUEST0    8'h20
`define OFS_REQUEST1    8'h24
`define OFS_REQUEST2    8'h28
`define OFS_REQUEST3    8'h2c
`define OFS_REQUEST4    8'h30

// Implemented enable bits of each word; all other positions read zero.
`define MASK_WORD0      16'h7fff
`define MASK_WORD1      16'hfffb
`define MASK_WORD2      16'hdfff
`define MASK_WORD3      16'h21ff
`define MASK_WORD4      16'h00f6

// Reset value of every enable word: all sources masked.
`define RESET_ENABLE    16'h0000

// Priority field of a source: width and the code that disables it.
`define PRIO_W          3
`define PRIO_OFF        3'h0

// Decoded register index: 0..4 enable words, 5..9 request words.
`define IDX_REQ_BASE    4'h5
`define IDX_NONE        4'hf

// Bus answer codes.
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// *** logic/axil_hold_slot.v ***
// One-entry holding slot for a bus channel payload.
// Assumes the producer and consumer run on aclk; ready drops while full.
module axil_hold_slot #(
   parameter W = 8
) (
   // Clock, reset and freeze.
   input  wire         aclk,
   input  wire         aresetn,
   input  wire         ce,
   // Filling side.
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   // Draining side.
   input  wire         take,
   output reg          full_q,
   output reg  [W-1:0] data_q
);

   // Ready only while empty and not frozen, so no beat is lost.
   assign in_ready = ce & ~full_q;

   // Catch a beat, hold it until the consumer takes it.
   always @(posedge aclk) begin
      if (!aresetn) begin
         full_q <= 1'b0;
         data_q <= {W{1'b0}};
      end else if (ce) begin
         if (in_valid && !full_q) begin
            full_q <= 1'b1;
            data_q <= in_data;
         end else if (take) begin
            full_q <= 1'b0;
         end
      end
   end

endmodule // axil_hold_slot

// *** logic/irq_enable_word.v ***
// One 16-bit enable word and the gating of its sixteen source requests.
// Assumes flags and priority fields come from logic on aclk.
`include "irq_enable_consts.vh"

module irq_enable_word #(
   parameter [15:0] IMPL_MASK = 16'hffff
) (
   // Clock, reset and freeze.
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        ce,
   // Register write.
   input  wire        wr_en,
   input  wire [15:0] wr_data,
   input  wire [1:0]  wr_strb,
   // Sources.
   input  wire [15:0] pend_flags,
   input  wire [47:0] prio_fields,
   // Results.
   output reg  [15:0] enable_q,
   output reg  [15:0] request_q
);

   reg [15:0] prio_live;
   reg [15:0] merged;
   integer    i;

   // A source with a zero priority field stays silent.
   always @* begin
      prio_live = 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
         prio_live[i] = (prio_fields[i*3 +: 3] != `PRIO_OFF); // R14
      end
   end

   // Byte-lane merge of a write; unimplemented positions never store.
   always @* begin
      merged = enable_q;
      if (wr_strb[0]) begin
         merged[7:0] = wr_data[7:0];
      end
      if (wr_strb[1]) begin
         merged[15:8] = wr_data[15:8];
      end
      merged = merged & IMPL_MASK; // R2
   end

   // Enable storage and registered request gating.
   always @(posedge aclk) begin
      if (!aresetn) begin
         enable_q  <= `RESET_ENABLE; // R3
         request_q <= 16'h0000;
      end else if (ce) begin
         if (wr_en) begin
            enable_q <= merged; // R4
         end
         request_q <= pend_flags & enable_q & prio_live & IMPL_MASK; // R1 R13 R15
      end
   end

endmodule // irq_enable_word

// *** logic/irq_enable_bank.v ***
// Interrupt enable bank: five enable words reached over AXI4-Lite, each
// gating sixteen peripheral requests toward the interrupt arbiter.
// Assumes flags, priority fields and the bus all run on aclk.
//
// Overview of operation
// [R1] An enable bit at one passes its source request; at zero blocks it.
// [R2] Unimplemented enable positions always read zero and ignore writes.
// [R3] Reset clears every implemented enable bit, masking all sources.
// [R4] Implemented enable bits are read and written; reads return last write.
// [R5] Word 0 bits 2..0: output compare 1, input capture 1, external irq 0.
// [R6] Word 1 bits 15..8: uart2 tx/rx, ext irq 2, timers, compares, dma2.
// [R7] Word 1 bits 7..3 capture/adc2/ext1/change; bit 2 empty; 1..0 i2c1.
// [R8] Word 2 bits 15,14 timer6, dma4; 13 empty; 12..9 compares; 8 capture6.
// [R9] Word 2 bits 7..4 captures, dma3; 3..2 can1; 1..0 spi2 event, error.
// [R10] Word 3 implements only bits 13, 8 and 7..0.
// [R11] Word 4 implements bits 7..4, 2 and 1 only.
// [R12] Word 2 bit 13 is reserved and reads zero.
// [R13] Each source pending flag is forwarded only when its enable is set.
// [R14] A zero priority field disables its source regardless of enable.
// [R15] Each request output is flag AND enable AND a nonzero priority field, registered on aclk.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.

`include "irq_enable_consts.vh"

module irq_enable_bank (
   // Clock, reset and freeze.
   input  wire                   aclk,
   input  wire                   aresetn,
   input  wire                   ce,
   // Write address channel.
   input  wire [`REG_ADDR_W-1:0] awaddr,
   input  wire                   awvalid,
   output wire                   awready,
   // Write data channel.
   input  wire [31:0]            wdata,
   input  wire [3:0]             wstrb,
   input  wire                   wvalid,
   output wire                   wready,
   // Write response channel.
   output reg  [1:0]             bresp,
   output reg                    bvalid,
   input  wire                   bready,
   // Read address channel.
   input  wire [`REG_ADDR_W-1:0] araddr,
   input  wire                   arvalid,
   output wire                   arready,
   // Read data channel.
   output reg  [31:0]            rdata,
   output reg  [1:0]             rresp,
   output reg                    rvalid,
   input  wire                   rready,
   // Pending flags of the sources, one word each.
   input  wire [15:0]            pend_flags0,
   input  wire [15:0]            pend_flags1,
   input  wire [15:0]            pend_flags2,
   input  wire [15:0]            pend_flags3,
   input  wire [15:0]            pend_flags4,
   // Three-bit priority fields, source n at bits 3n+2..3n.
   input  wire [47:0]            prio_fields0,
   input  wire [47:0]            prio_fields1,
   input  wire [47:0]            prio_fields2,
   input  wire [47:0]            prio_fields3,
   input  wire [47:0]            prio_fields4,
   // Gated requests toward the arbiter.
   output wire [15:0]            irq_request0,
   output wire [15:0]            irq_request1,
   output wire [15:0]            irq_request2,
   output wire [15:0]            irq_request3,
   output wire [15:0]            irq_request4
);

   ////////////////////////////////////////////////////////////////////////
   // Address decoding.

   // Maps a byte address to a register index, or to none if unmapped.
   function [3:0] reg_index;
      input [`REG_ADDR_W-1:0] addr;
      begin
         case (addr)
            `OFS_ENABLE0:  reg_index = 4'h0;
            `OFS_ENABLE1:  reg_index = 4'h1;
            `OFS_ENABLE2:  reg_index = 4'h2;
            `OFS_ENABLE3:  reg_index = 4'h3;
            `OFS_ENABLE4:  reg_index = 4'h4;
            `OFS_REQUEST0: reg_index = 4'h5;
            `OFS_REQUEST1: reg_index = 4'h6;
            `OFS_REQUEST2: reg_index = 4'h7;
            `OFS_REQUEST3: reg_index = 4'h8;
            `OFS_REQUEST4: reg_index = 4'h9;
            default:       reg_index = `IDX_NONE;
         endcase
      end
   endfunction

   // True when the index names one of the writable enable words.
   function is_enable_word;
      input [3:0] idx;
      begin
         is_enable_word = (idx < `IDX_REQ_BASE);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Write channels: address and data are caught separately, any order.

   wire                   aw_full_q;
   wire [`REG_ADDR_W-1:0] aw_addr_q;
   wire                   w_full_q;
   wire [35:0]            w_beat_q;
   wire                   wr_fire;

   axil_hold_slot #(
      .W (`REG_ADDR_W)
   ) u_aw_slot (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (ce),
      .in_valid (awvalid),
      .in_ready (awready),
      .in_data  (awaddr),
      .take     (wr_fire),
      .full_q   (aw_full_q),
      .data_q   (aw_addr_q)
   );

   axil_hold_slot #(
      .W (36)
   ) u_w_slot (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (ce),
      .in_valid (wvalid),
      .in_ready (wready),
      .in_data  ({wstrb, wdata}),
      .take     (wr_fire),
      .full_q   (w_full_q),
      .data_q   (w_beat_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Write execution and response.

   wire [3:0]  wr_idx;
   wire [15:0] wr_data;
   wire [1:0]  wr_strb;
   wire [4:0]  wr_sel;

   // The write happens once both halves are held and no response waits.
   assign wr_fire = ce & aw_full_q & w_full_q & ~bvalid;
   assign wr_idx  = reg_index(aw_addr_q);
   assign wr_data = w_beat_q[15:0];
   assign wr_strb = w_beat_q[33:32];

   // One-hot strobe per enable word; request words ignore writes.
   assign wr_sel[0] = wr_fire & (wr_idx == 4'h0);
   assign wr_sel[1] = wr_fire & (wr_idx == 4'h1);
   assign wr_sel[2] = wr_fire & (wr_idx == 4'h2);
   assign wr_sel[3] = wr_fire & (wr_idx == 4'h3);
   assign wr_sel[4] = wr_fire & (wr_idx == 4'h4);

   // Response is raised the cycle after the write and held until bready.
   always @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= `RESP_OKAY;
      end else if (ce) begin
         if (wr_fire) begin
            bvalid <= 1'b1;
            if (wr_idx == `IDX_NONE) begin
               bresp <= `RESP_SLVERR;
            end else begin
               bresp <= `RESP_OKAY;
            end
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Enable words and request gating.

   wire [15:0] enable0_q;
   wire [15:0] enable1_q;
   wire [15:0] enable2_q;
   wire [15:0] enable3_q;
   wire [15:0] enable4_q;

   // Word 0: bit 2 compare 1, bit 1 capture 1, bit 0 external irq 0.
   irq_enable_word #(
      .IMPL_MASK (`MASK_WORD0) // R5
   ) u_word0 (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .ce          (ce),
      .wr_en       (wr_sel[0]),
      .wr_data     (wr_data),
      .wr_strb     (wr_strb),
      .pend_flags  (pend_flags0),
      .prio_fields (prio_fields0),
      .enable_q    (enable0_q),
      .request_q   (irq_request0)
   );

   // Word 1: every bit but bit 2 is an enable.
   irq_enable_word #(
      .IMPL_MASK (`MASK_WORD1) // R6 R7
   ) u_word1 (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .ce          (ce),
      .wr_en       (wr_sel[1]),
      .wr_data     (wr_data),
      .wr_strb     (wr_strb),
      .pend_flags  (pend_flags1),
      .prio_fields (prio_fields1),
      .enable_q    (enable1_q),
      .request_q   (irq_request1)
   );

   // Word 2: bit 13 is a reserved hole between dma4 and compare 8.
   irq_enable_word #(
      .IMPL_MASK (`MASK_WORD2) // R8 R9 R12
   ) u_word2 (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .ce          (ce),
      .wr_en       (wr_sel[2]),
      .wr_data     (wr_data),
      .wr_strb     (wr_strb),
      .pend_flags  (pend_flags2),
      .prio_fields (prio_fields2),
      .enable_q    (enable2_q),
      .request_q   (irq_request2)
   );

   // Word 3: dma5 at bit 13, can2 event at bit 8, bits 7..0 in use.
   irq_enable_word #(
      .IMPL_MASK (`MASK_WORD3) // R10
   ) u_word3 (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .ce          (ce),
      .wr_en       (wr_sel[3]),
      .wr_data     (wr_data),
      .wr_strb     (wr_strb),
      .pend_flags  (pend_flags3),
      .prio_fields (prio_fields3),
      .enable_q    (enable3_q),
      .request_q   (irq_request3)
   );

   // Word 4: transmit requests, dma7, dma6 and the uart error enables.
   irq_enable_word #(
      .IMPL_MASK (`MASK_WORD4) // R11
   ) u_word4 (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .ce          (ce),
      .wr_en       (wr_sel[4]),
      .wr_data     (wr_data),
      .wr_strb     (wr_strb),
      .pend_flags  (pend_flags4),
      .prio_fields (prio_fields4),
      .enable_q    (enable4_q),
      .request_q   (irq_request4)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read path.

   wire [3:0] rd_idx;
   wire       rd_fire;
   reg [15:0] rd_word;

   // One read at a time: the address is refused while data waits.
   assign arready = ce & ~rvalid;
   assign rd_fire = arvalid & arready;
   assign rd_idx  = reg_index(araddr);

   // Selects the word to return; upper half and holes read zero.
   always @* begin
      case (rd_idx)
         4'h0:    rd_word = enable0_q; // R4
         4'h1:    rd_word = enable1_q;
         4'h2:    rd_word = enable2_q;
         4'h3:    rd_word = enable3_q;
         4'h4:    rd_word = enable4_q;
         4'h5:    rd_word = irq_request0;
         4'h6:    rd_word = irq_request1;
         4'h7:    rd_word = irq_request2;
         4'h8:    rd_word = irq_request3;
         4'h9:    rd_word = irq_request4;
         default: rd_word = 16'h0000;
      endcase
   end

   // Read data is registered and held until rready.
   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= `RESP_OKAY;
      end else if (ce) begin
         if (rd_fire) begin
            rvalid <= 1'b1;
            rdata  <= {16'h0000, rd_word}; // R2
            if (rd_idx == `IDX_NONE) begin
               rresp <= `RESP_SLVERR;
            end else if (is_enable_word(rd_idx) || rd_idx < 4'ha) begin
               rresp <= `RESP_OKAY;
            end else begin
               rresp <= `RESP_SLVERR;
            end
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

endmodule // irq_enable_bank

// *** bench/irq_enable_bank_props.sv ***
// Checker for the interrupt enable bank, watching only its top-level ports.
// Assumes a single aclk domain with a synchronous active-low reset.
`include "irq_enable_consts.vh"

module irq_enable_bank_props (
   // Clock, reset and freeze.
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        ce,
   // Bus handshakes and answers.
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   // Sources and gated requests.
   input wire logic [15:0] pend_flags2,
   input wire logic [47:0] prio_fields2,
   input wire logic [15:0] irq_request0,
   input wire logic [15:0] irq_request2,
   input wire logic [15:0] irq_request3,
   input wire logic [15:0] irq_request4
);
   timeunit 1ns;
   timeprecision 1ps;

   // All checks share the bus clock and are quiet while reset is held.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////////////////////
   // Bus answers.
   a_bvalid_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped before it was taken");
   a_rvalid_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer changed before it was taken");
   a_rdata_upper: assert property (rvalid |-> rdata[31:16] == 16'h0000)
      else $error("upper read lanes not zero");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_write_answer: assert property ((awvalid && awready && wvalid && wready && !bvalid)
      ##1 ce [*2] |-> bvalid)
      else $error("write answer late");
   a_ce_freeze: assert property (!ce |-> !awready && !wready && !arready)
      else $error("bus accepted while frozen");

   ////////////////////////////////////////////////////////////////////////////////
   // Request gating.
   a_unimpl_req: assert property ((irq_request2 & ~`MASK_WORD2) == 16'h0000
      && (irq_request3 & ~`MASK_WORD3) == 16'h0000
      && (irq_request4 & ~`MASK_WORD4) == 16'h0000)
      else $error("request on an empty position");
   a_flag_gate: assert property ($past(ce)
      |-> (irq_request2 & ~$past(pend_flags2)) == 16'h0000)
      else $error("request without pending flag");
   a_prio_off: assert property ($past(ce) && $past(prio_fields2[2:0]) == 3'h0
      |-> !irq_request2[0])
      else $error("request with priority zero");
   a_reset_clear: assert property ($past(!aresetn && ce)
      |-> irq_request0 == 16'h0000 && !bvalid && !rvalid)
      else $error("state not cleared by reset");
endmodule // irq_enable_bank_props

bind irq_enable_bank irq_enable_bank_props i_props (
   .aclk, .aresetn, .ce, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
   .arvalid, .arready, .rdata, .rvalid, .rready, .pend_flags2, .prio_fields2,
   .irq_request0, .irq_request2, .irq_request3, .irq_request4
);

// *** bench/irq_enable_bank_tb_top.sv ***
// Self-checking bench of the interrupt enable bank, driven over AXI4-Lite.
// Assumes the checker is bound from its own file.
`include "irq_enable_consts.vh"

module irq_enable_bank_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        ce = 1'b1;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  wstrb = 4'h0;
   wire         awready, wready, bvalid, arready, rvalid;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   logic [15:0] flags [0:4] = '{5{16'h0000}};
   logic [47:0] prio [0:4] = '{5{48'h2492_4924_9249}};
   wire  [15:0] req [0:4];
   logic [15:0] mask [0:4] = '{`MASK_WORD0, `MASK_WORD1, `MASK_WORD2, `MASK_WORD3, `MASK_WORD4};
   logic [15:0] pats [0:2] = '{16'h5555, 16'haaaa, 16'hffff};
   int          err_count = 0;
   int          check_count = 0;
   int          cyc = 0;

   irq_enable_bank i_dut (
      .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .pend_flags0(flags[0]), .pend_flags1(flags[1]), .pend_flags2(flags[2]),
      .pend_flags3(flags[3]), .pend_flags4(flags[4]),
      .prio_fields0(prio[0]), .prio_fields1(prio[1]), .prio_fields2(prio[2]),
      .prio_fields3(prio[3]), .prio_fields4(prio[4]),
      .irq_request0(req[0]), .irq_request1(req[1]), .irq_request2(req[2]),
      .irq_request3(req[3]), .irq_request4(req[4])
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard.
   always #2.5 aclk = ~aclk;

   // Cuts a hung run short well beyond the expected length.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 4000) begin
         err_count++;
         $display("ERROR %0t: timeout", $time);
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and bus tasks.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Offers address and data together and releases each once taken.
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      bit aw_d;
      bit w_d;
      aw_d = 1'b0;
      w_d = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_d && w_d)) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) begin
            awvalid <= 1'b0;
            aw_d = 1'b1;
         end
         if (wvalid && wready === 1'b1) begin
            wvalid <= 1'b0;
            w_d = 1'b1;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      // The answer is left waiting one cycle, so it must hold until taken.
      bready <= 1'b1;
      @(posedge aclk);
      chk({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
   endtask

   // Reads one word and compares data and answer code.
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      // The data is left waiting one cycle, so it must hold until taken.
      rready <= 1'b1;
      @(posedge aclk);
      chk(rdata, {16'h0000, exp});
      chk({30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 5; i++) rd(8'(4 * i), 16'h0000, `RESP_OKAY);
      for (int p = 0; p < 3; p++)
         for (int i = 0; i < 5; i++) begin
            wr(8'(4 * i), pats[p], 4'hf, `RESP_OKAY);
            rd(8'(4 * i), pats[p] & mask[i], `RESP_OKAY);
         end
      // Each byte lane of a word is written only under its own strobe.
      wr(`OFS_ENABLE1, 16'h0000, 4'h1, `RESP_OKAY);
      rd(`OFS_ENABLE1, 16'hff00, `RESP_OKAY);
      wr(`OFS_ENABLE1, 16'h0000, 4'h2, `RESP_OKAY);
      wr(`OFS_ENABLE1, 16'h00ff, 4'h1, `RESP_OKAY);
      rd(`OFS_ENABLE1, 16'h00fb, `RESP_OKAY);
      wr(`OFS_ENABLE1, 16'hffff, 4'hf, `RESP_OKAY);
      // All flags raised with every source enabled and prioritised.
      for (int i = 0; i < 5; i++) flags[i] <= 16'hffff;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 5; i++) chk({16'h0000, req[i]}, {16'h0000, mask[i]});
      for (int i = 0; i < 5; i++) rd(8'(`OFS_REQUEST0 + 4 * i), mask[i], `RESP_OKAY);
      // One enable cleared, one priority zeroed, one word of flags dropped.
      wr(`OFS_ENABLE2, 16'h5fff, 4'hf, `RESP_OKAY);
      prio[2][2:0] <= 3'h0;
      flags[4] <= 16'h0000;
      repeat (2) @(posedge aclk);
      chk({16'h0000, req[2]}, 32'h0000_5ffe);
      chk({16'h0000, req[4]}, 32'h0000_0000);
      // Request words ignore writes; unmapped places answer with an error.
      wr(`OFS_REQUEST0, 16'h0000, 4'hf, `RESP_OKAY);
      rd(`OFS_REQUEST0, `MASK_WORD0, `RESP_OKAY);
      wr(8'h40, 16'hffff, 4'hf, `RESP_SLVERR);
      rd(8'h40, 16'h0000, `RESP_SLVERR);
      // Frozen clock enable keeps state, then the dropped flags take effect.
      ce <= 1'b0;
      flags[0] <= 16'h0000;
      repeat (4) @(posedge aclk);
      chk({16'h0000, req[0]}, {16'h0000, `MASK_WORD0});
      ce <= 1'b1;
      repeat (2) @(posedge aclk);
      chk({16'h0000, req[0]}, 32'h0000_0000);
      rd(`OFS_ENABLE0, `MASK_WORD0, `RESP_OKAY);
      // A second reset in mid-run masks every source again.
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 5; i++) rd(8'(4 * i), 16'h0000, `RESP_OKAY);
      chk({16'h0000, req[0]}, 32'h0000_0000);
      give_verdict();
   end
endmodule // irq_enable_bank_tb_top
